/* bench/tapwm_pulse_load.sv */
// Load on the pulse output that measures high width, period and edge counts.
`timescale 1ns/1ps
`default_nettype none

module tapwm_pulse_load (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pulse,
  output logic [23:0] hi_len,
  output logic [23:0] per_len,
  output logic [15:0] n_rise,
  output logic [15:0] n_fall
);
  logic prev;
  logic [23:0] hi_cnt;
  logic [23:0] per_cnt;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev <= 1'b0;
      hi_cnt <= 24'h000000;
      per_cnt <= 24'h000000;
      hi_len <= 24'h000000;
      per_len <= 24'h000000;
      n_rise <= 16'h0000;
      n_fall <= 16'h0000;
    end else begin
      prev <= pulse;
      hi_cnt <= pulse ? hi_cnt + 24'h000001 : 24'h000000;
      per_cnt <= (pulse && !prev) ? 24'h000001 : per_cnt + 24'h000001;
      if (pulse && !prev) begin
        n_rise <= n_rise + 16'h0001;
        per_len <= per_cnt;
      end
      if (!pulse && prev) begin
        n_fall <= n_fall + 16'h0001;
        hi_len <= hi_cnt;
      end
    end
  end
endmodule : tapwm_pulse_load

`default_nettype wire

/* bench/tapwm_top_assertions.sv */
// Port-level checker of the PWM timer channel.
`timescale 1ns/1ps
`default_nettype none

module tapwm_top_assertions (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [tapwm_pkg::AW-1:0] ADDR,
  input wire logic [tapwm_pkg::DW-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [tapwm_pkg::DW-1:0] RDATA,
  input wire logic TRIG_PIN,
  input wire logic OVF_IN,
  input wire logic SUBCLK_PIN,
  input wire logic PULSE_OUT,
  input wire logic IRQ
);
  // ----------------------------------------------------------------
  // Shadow of the software settings and pulse timing
  // ----------------------------------------------------------------
  logic st_wr, run_q, stop_q, p_q, per_ok;
  logic [4:0] mode_q;
  logic [1:0] mask_q;
  logic [15:0] reload_q, rl_rise;
  logic [23:0] hi_cnt, per_cnt, n8, m1, exp_hi, exp_per;

  assign st_wr = WR && ADDR == tapwm_pkg::REG_START;
  assign n8 = {16'h0000, rl_rise[15:8]};
  assign m1 = {16'h0000, rl_rise[7:0]} + 24'h000001;
  assign exp_hi = mode_q[0] ? n8 * m1 : {8'h00, rl_rise};
  assign exp_per = mode_q[0] ? 24'h0000FF * m1 : 24'h00FFFF;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      {run_q, stop_q, p_q, per_ok, mode_q, mask_q} <= '0;
      {reload_q, rl_rise, hi_cnt, per_cnt} <= '0;
    end else begin
      p_q <= PULSE_OUT;
      stop_q <= st_wr && !WDATA[0];
      if (st_wr) run_q <= WDATA[0];
      if (WR && ADDR == tapwm_pkg::REG_MODE && !run_q) mode_q <= WDATA[4:0];
      if (WR && ADDR == tapwm_pkg::REG_TIMER) reload_q <= WDATA;
      if (WR && ADDR == tapwm_pkg::REG_MASK) mask_q <= WDATA[1:0];
      if (PULSE_OUT && !p_q) rl_rise <= reload_q;
      hi_cnt <= PULSE_OUT ? hi_cnt + 24'h000001 : 24'h000000;
      per_cnt <= (PULSE_OUT && !p_q) ? 24'h000001 : per_cnt + 24'h000001;
      if (stop_q) per_ok <= 1'b0;
      else if (PULSE_OUT && !p_q) per_ok <= 1'b1;
    end
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);

  AST_TIMER_READ: assert property (RD && ADDR == tapwm_pkg::REG_TIMER |=>
    RDATA == tapwm_pkg::TIMER_READ_VAL) else $error("timer read not fixed");
  AST_RDATA_IDLE: assert property (!$past(RD) |-> RDATA == 16'h0000)
    else $error("read data outside read cycle");
  AST_STOP: assert property (st_wr && !WDATA[0] |=> !PULSE_OUT)
    else $error("pulse high after stop");
  AST_SOFT_START: assert property (st_wr && WDATA[0] && !run_q && mode_q[4:3] == 2'b00 &&
    !mode_q[0] && reload_q != 16'h0000 |=> PULSE_OUT) else $error("no soft start");
  AST_ARMED: assert property (st_wr && WDATA[0] && !run_q && mode_q[4:3] != 2'b00
    |=> !PULSE_OUT) else $error("started without trigger");
  AST_IRQ_FALL: assert property ($fell(PULSE_OUT) && !stop_q && mask_q[0] |-> IRQ)
    else $error("no interrupt on pulse fall");
  AST_IRQ_MASK: assert property (IRQ |-> mask_q != 2'b00)
    else $error("interrupt while masked");
  AST_HIGH: assert property ($fell(PULSE_OUT) && !stop_q && mode_q[2:1] == 2'b00
    |-> hi_cnt == exp_hi) else $error("high width wrong");
  AST_PERIOD: assert property ($rose(PULSE_OUT) && per_ok && mode_q[2:1] == 2'b00
    |-> per_cnt == exp_per) else $error("period wrong");
endmodule : tapwm_top_assertions

bind tapwm_top tapwm_top_assertions u_chk (.CLK, .RSTN, .ADDR, .WDATA, .WR, .RD, .RDATA,
  .TRIG_PIN, .OVF_IN, .SUBCLK_PIN, .PULSE_OUT, .IRQ);

`default_nettype wire

/* bench/tb_top.sv */
// Self-checking testbench of the PWM timer channel.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic CLK, RSTN, WR, RD, TRIG_PIN, OVF_IN, SUBCLK_PIN, PULSE_OUT, IRQ;
  logic [tapwm_pkg::AW-1:0] ADDR;
  logic [tapwm_pkg::DW-1:0] WDATA, RDATA;
  logic [15:0] n_rise, n_fall, base;
  logic [23:0] hi_len, per_len;
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;

  tapwm_top DUT (.CLK, .RSTN, .ADDR, .WDATA, .WR, .RD, .RDATA, .TRIG_PIN, .OVF_IN,
    .SUBCLK_PIN, .PULSE_OUT, .IRQ);
  tapwm_pulse_load load (.clk(CLK), .rst_n(RSTN), .pulse(PULSE_OUT), .hi_len, .per_len,
    .n_rise, .n_fall);

  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end

  // Subclock runs at half the system rate; the timeout counts cycles.
  always @(posedge CLK) begin
    SUBCLK_PIN <= RSTN ? ~SUBCLK_PIN : 1'b0;
    cyc++;
    if (cyc == 100000) begin
      miscompares++;
      $display("[ERR] %0t timeout", $time);
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task give_verdict;
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict

  task chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [tapwm_pkg::AW-1:0] a, input logic [15:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr

  task rd(input logic [tapwm_pkg::AW-1:0] a, input logic [15:0] e);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 chk(24'(RDATA), 24'(e));
  endtask : rd

  task run(input logic [15:0] mode, input logic [15:0] tmr);
    wr(tapwm_pkg::REG_MODE, mode);
    wr(tapwm_pkg::REG_TIMER, tmr);
    wr(tapwm_pkg::REG_STAT, 16'h0003);
    wr(tapwm_pkg::REG_START, 16'h0001);
  endtask : run

  task wait_falls(input int k);
    logic [15:0] t;
    t = n_fall + 16'(k);
    repeat (70000) if (n_fall !== t) begin
      @(posedge CLK);
      #1;
    end
    chk(24'(n_fall), 24'(t));
  endtask : wait_falls

  task fire(input int t);
    @(posedge CLK);
    TRIG_PIN <= 1'b1;
    OVF_IN <= (t == 3);
    @(posedge CLK);
    OVF_IN <= 1'b0;
    repeat (4) @(posedge CLK);
    rd(tapwm_pkg::REG_PORT, 16'h0001);
    @(posedge CLK);
    TRIG_PIN <= 1'b0;
  endtask : fire

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {RSTN, WR, RD, TRIG_PIN, OVF_IN} = '0;
    ADDR = '0;
    WDATA = '0;
    repeat (16) @(posedge CLK);
    RSTN <= 1'b1;
    for (int a = 0; a <= 8'h1C; a += 4) rd(8'(a), 16'h0000);
    run(16'h0001, 16'h0201);
    wait_falls(2);
    chk(hi_len, 24'h000004);
    chk(per_len, 24'h0001FE);
    wr(tapwm_pkg::REG_MODE, 16'h0000);
    rd(tapwm_pkg::REG_MODE, 16'h0001);
    wr(tapwm_pkg::REG_TIMER, 16'hF000);
    wait_falls(1);
    chk(hi_len, 24'h0000F0);
    wait_falls(1);
    chk(per_len, 24'h0000FF);
    repeat (30) @(posedge CLK);
    wr(tapwm_pkg::REG_STAT, 16'h0003);
    wr(tapwm_pkg::REG_START, 16'h0000);
    @(posedge CLK);
    #1 chk(24'(PULSE_OUT), 24'h000000);
    rd(tapwm_pkg::REG_STAT, 16'h0000);
    for (int s = 1; s < 3; s++) begin
      run(16'(1 + 2 * s), 16'h0100);
      wait_falls(3);
      chk(hi_len, (s == 1) ? 24'h000008 : 24'h000020);
      chk(per_len, (s == 1) ? 24'h0007F8 : 24'h001FE0);
      wr(tapwm_pkg::REG_START, 16'h0000);
    end
    for (int t = 1; t < 4; t++) begin
      run(16'(1 + 8 * t), 16'h0100);
      base = n_rise;
      repeat (6) @(posedge CLK);
      #1 chk(24'(n_rise - base), 24'h000000);
      fire(t);
      repeat (12) @(posedge CLK);
      #1 chk(24'(n_rise - base), 24'h000001);
      fire(t);
      repeat (12) @(posedge CLK);
      #1 chk(24'(n_rise - base), 24'h000001);
      wait_falls(1);
      chk(per_len, 24'h0000FF);
      wr(tapwm_pkg::REG_START, 16'h0000);
    end
    wr(tapwm_pkg::REG_MASK, 16'h0001);
    run(16'h0000, 16'h0003);
    rd(tapwm_pkg::REG_TIMER, 16'h0000);
    wait_falls(1);
    chk(hi_len, 24'h000003);
    chk(24'(IRQ), 24'h000001);
    rd(tapwm_pkg::REG_STAT, 16'h0003);
    wr(tapwm_pkg::REG_MASK, 16'h0000);
    wr(tapwm_pkg::REG_STAT, 16'h0003);
    wait_falls(1);
    chk(per_len, 24'h00FFFF);
    chk(24'(IRQ), 24'h000000);
    wr(tapwm_pkg::REG_MASK, 16'h0001);
    #1 chk(24'(IRQ), 24'h000001);
    wr(tapwm_pkg::REG_STAT, 16'h0001);
    #1 chk(24'(IRQ), 24'h000000);
    wr(tapwm_pkg::REG_START, 16'h0000);
    run(16'h0006, 16'h0002);
    wait_falls(1);
    chk(24'(hi_len > 24'h000040 && hi_len <= 24'h000080), 24'h000001);
    give_verdict();
  end
endmodule : tb_top

`default_nettype wire

/* common/tapwm_pkg.sv */
// Constants, register map and types of the PWM timer channel.
`default_nettype none

package tapwm_pkg;

  // ----------------------------------------------------------------
  // Bus widths
  // ----------------------------------------------------------------
  localparam int AW = 8;
  localparam int DW = 16;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [AW-1:0] REG_MODE = 8'h00;
  localparam logic [AW-1:0] REG_START = 8'h04;
  localparam logic [AW-1:0] REG_TIMER = 8'h08;
  localparam logic [AW-1:0] REG_STAT = 8'h0C;
  localparam logic [AW-1:0] REG_MASK = 8'h10;
  localparam logic [AW-1:0] REG_PORT = 8'h14;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int MODE_PWM8_BIT = 0;
  localparam int MODE_SRC_LSB = 1;
  localparam int MODE_TRG_LSB = 3;
  localparam int START_BIT = 0;
  localparam int STAT_FALL_BIT = 0;
  localparam int STAT_START_BIT = 1;
  localparam int STAT_W = 2;
  localparam logic [DW-1:0] TIMER_RESET = 16'h0000;
  localparam logic [DW-1:0] TIMER_READ_VAL = 16'h0000;

  // ----------------------------------------------------------------
  // Count figures
  // ----------------------------------------------------------------
  localparam logic [15:0] PER16_LAST = 16'hFFFE;
  localparam logic [15:0] PER8_LAST = 16'h00FE;
  localparam logic [4:0] DIV8_LAST = 5'h07;
  localparam logic [4:0] DIV32_LAST = 5'h1F;
  localparam logic [4:0] SUB_DIV_LAST = 5'h1F;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_UNDIV = 2'b00,
    SRC_DIV8 = 2'b01,
    SRC_DIV32 = 2'b10,
    SRC_SUB32 = 2'b11
  } tapwm_src_t;

  typedef enum logic [1:0] {
    TRG_SOFT = 2'b00,
    TRG_RISE = 2'b01,
    TRG_FALL = 2'b10,
    TRG_OVF = 2'b11
  } tapwm_trg_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARMED = 2'b01,
    ST_RUN = 2'b10
  } tapwm_state_t;

endpackage : tapwm_pkg

`default_nettype wire

/* common/tapwm_tick_if.sv */
// Count clock selection and tick between the timer core and its prescaler.
`timescale 1ns/1ps
`default_nettype none

interface tapwm_tick_if;
  tapwm_pkg::tapwm_src_t src;
  logic tick;

  modport ctl (output src, input tick);
  modport gen (input src, output tick);
endinterface : tapwm_tick_if

`default_nettype wire

/* hdl/tapwm_prescale.sv */
// Prescaler making the selected count clock as a one-cycle enable.
`timescale 1ns/1ps
`default_nettype none

module tapwm_prescale (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sub_clk_pin,
  tapwm_tick_if.gen tk
);

  // ----------------------------------------------------------------
  // Main clock dividers
  // ----------------------------------------------------------------
  logic [4:0] div_cnt;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 5'h00;
    end else begin
      div_cnt <= div_cnt + 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // Subclock synchroniser and divide by 32
  // ----------------------------------------------------------------
  logic sub_s1;
  logic sub_s2;
  logic sub_s3;
  logic [4:0] sub_cnt;
  logic sub_tick;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sub_s1 <= 1'b0;
      sub_s2 <= 1'b0;
      sub_s3 <= 1'b0;
    end else begin
      sub_s1 <= sub_clk_pin;
      sub_s2 <= sub_s1;
      sub_s3 <= sub_s2;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sub_cnt <= 5'h00;
    end else if (sub_s2 && !sub_s3) begin
      sub_cnt <= sub_cnt + 5'h01;
    end
  end

  assign sub_tick = sub_s2 && !sub_s3 && (sub_cnt == tapwm_pkg::SUB_DIV_LAST);

  // ----------------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------------
  always_comb begin
    case (tk.src)
      tapwm_pkg::SRC_UNDIV: tk.tick = 1'b1;
      tapwm_pkg::SRC_DIV8: tk.tick = (div_cnt[2:0] == tapwm_pkg::DIV8_LAST[2:0]);
      tapwm_pkg::SRC_DIV32: tk.tick = (div_cnt == tapwm_pkg::DIV32_LAST);
      tapwm_pkg::SRC_SUB32: tk.tick = sub_tick;
      default: tk.tick = 1'b0;
    endcase
  end

endmodule : tapwm_prescale

`default_nettype wire

/* hdl/tapwm_top.sv */
// Timer channel in pulse width modulation mode, with register port and interrupt.
//
// Functional notes
// - Counts down on a divided or undivided clock, 16-bit or 8-bit modulator.
// - At each pulse rising edge the count reloads from reload register and continues.
// - Triggers arriving while counting are ignored, no restart or reload.
// - 16-bit: high for n count clocks, period 65535 count clocks.
// - 8-bit: high n*(m+1) count clocks, period 255*(m+1) count clocks.
// - Start on trigger pin edge, other timer overflow, or start flag set.
// - Clearing the start flag stops counting.
// - Interrupt request each time the pulse output falls low, except when a stop forces it low.
// - Input pin is port or trigger; output pin carries the pulse.
// - Reading the timer register returns a fixed value, not the count.
// - Timer write while stopped loads reload register and counter.
// - Timer write while counting loads only reload register, used at next reload.
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module tapwm_top (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [tapwm_pkg::AW-1:0] ADDR,
  input wire logic [tapwm_pkg::DW-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [tapwm_pkg::DW-1:0] RDATA,
  input wire logic TRIG_PIN,
  input wire logic OVF_IN,
  input wire logic SUBCLK_PIN,
  output logic PULSE_OUT,
  output logic IRQ
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [tapwm_pkg::AW-1:0] a,
                               input logic [tapwm_pkg::AW-1:0] off);
    hit = (a == off);
  endfunction : hit

  logic wr_mode;
  logic wr_start;
  logic wr_timer;
  logic wr_stat;
  logic wr_mask;

  assign wr_mode = WR && hit(ADDR, tapwm_pkg::REG_MODE);
  assign wr_start = WR && hit(ADDR, tapwm_pkg::REG_START);
  assign wr_timer = WR && hit(ADDR, tapwm_pkg::REG_TIMER);
  assign wr_stat = WR && hit(ADDR, tapwm_pkg::REG_STAT);
  assign wr_mask = WR && hit(ADDR, tapwm_pkg::REG_MASK);

  // ----------------------------------------------------------------
  // Mode register
  // ----------------------------------------------------------------
  tapwm_pkg::tapwm_state_t state;
  tapwm_pkg::tapwm_state_t next_state;
  logic pwm8;
  tapwm_pkg::tapwm_src_t src;
  tapwm_pkg::tapwm_trg_t trg;

  // Mode fields only change while the channel is idle.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pwm8 <= 1'b0;
      src <= tapwm_pkg::SRC_UNDIV;
      trg <= tapwm_pkg::TRG_SOFT;
    end else if (wr_mode && (state == tapwm_pkg::ST_IDLE)) begin
      pwm8 <= WDATA[tapwm_pkg::MODE_PWM8_BIT];
      src <= tapwm_pkg::tapwm_src_t'(WDATA[tapwm_pkg::MODE_SRC_LSB +: 2]);
      trg <= tapwm_pkg::tapwm_trg_t'(WDATA[tapwm_pkg::MODE_TRG_LSB +: 2]);
    end
  end

  // ----------------------------------------------------------------
  // Count clock
  // ----------------------------------------------------------------
  tapwm_tick_if tk_if ();

  assign tk_if.src = src;

  tapwm_prescale u_prescale (
    .clk(CLK),
    .rst_n(RSTN),
    .sub_clk_pin(SUBCLK_PIN),
    .tk(tk_if.gen)
  );

  // ----------------------------------------------------------------
  // Trigger pin synchroniser and edge detection
  // ----------------------------------------------------------------
  logic trig_s1;
  logic trig_s2;
  logic trig_s3;
  logic trig_evt;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      trig_s1 <= 1'b0;
      trig_s2 <= 1'b0;
      trig_s3 <= 1'b0;
    end else begin
      trig_s1 <= TRIG_PIN;
      trig_s2 <= trig_s1;
      trig_s3 <= trig_s2;
    end
  end

  always_comb begin
    case (trg)
      tapwm_pkg::TRG_RISE: trig_evt = trig_s2 && !trig_s3;
      tapwm_pkg::TRG_FALL: trig_evt = !trig_s2 && trig_s3;
      tapwm_pkg::TRG_OVF: trig_evt = OVF_IN;
      default: trig_evt = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Start flag and run control
  // ----------------------------------------------------------------
  logic start_flag;
  logic go;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      start_flag <= 1'b0;
    end else if (wr_start) begin
      start_flag <= WDATA[tapwm_pkg::START_BIT];
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      tapwm_pkg::ST_IDLE: begin
        if (wr_start && WDATA[tapwm_pkg::START_BIT]) begin
          if (trg == tapwm_pkg::TRG_SOFT) begin
            next_state = tapwm_pkg::ST_RUN;
          end else begin
            next_state = tapwm_pkg::ST_ARMED;
          end
        end
      end
      tapwm_pkg::ST_ARMED: begin
        if (wr_start && !WDATA[tapwm_pkg::START_BIT]) begin
          next_state = tapwm_pkg::ST_IDLE;
        end else if (trig_evt) begin
          next_state = tapwm_pkg::ST_RUN;
        end
      end
      tapwm_pkg::ST_RUN: begin
        // Trigger events are not looked at once running.
        if (wr_start && !WDATA[tapwm_pkg::START_BIT]) begin
          next_state = tapwm_pkg::ST_IDLE;
        end
      end
      default: next_state = tapwm_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state <= tapwm_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign go = (state != tapwm_pkg::ST_RUN) && (next_state == tapwm_pkg::ST_RUN);

  // ----------------------------------------------------------------
  // Reload register
  // ----------------------------------------------------------------
  logic [tapwm_pkg::DW-1:0] reload;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      reload <= tapwm_pkg::TIMER_RESET;
    end else if (wr_timer) begin
      reload <= WDATA;
    end
  end

  // ----------------------------------------------------------------
  // Modulator counters
  // ----------------------------------------------------------------
  logic [15:0] cnt;
  logic [15:0] per_cnt;
  logic [7:0] pre_cnt;
  logic running;
  logic step;
  logic cyc_start;
  logic [15:0] high_n;

  assign running = (state == tapwm_pkg::ST_RUN);
  // In 8-bit mode the low byte scales each step to m+1 count clocks.
  assign step = running && tk_if.tick && (!pwm8 || (pre_cnt == 8'h00));
  assign cyc_start = go || (step && (per_cnt == 16'h0000));
  assign high_n = pwm8 ? {8'h00, reload[15:8]} : reload;

  // The low byte is latched at cycle start, so a write while counting waits for the next reload.
  logic [7:0] pre_m;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pre_m <= 8'h00;
    end else if (cyc_start) begin
      pre_m <= reload[7:0];
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pre_cnt <= 8'h00;
    end else if (cyc_start) begin
      pre_cnt <= reload[7:0];
    end else if (running && tk_if.tick && pwm8) begin
      if (pre_cnt == 8'h00) begin
        pre_cnt <= pre_m;
      end else begin
        pre_cnt <= pre_cnt - 8'h01;
      end
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      per_cnt <= 16'h0000;
    end else if (cyc_start) begin
      per_cnt <= pwm8 ? tapwm_pkg::PER8_LAST : tapwm_pkg::PER16_LAST;
    end else if (step) begin
      per_cnt <= per_cnt - 16'h0001;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      cnt <= 16'h0000;
    end else if (cyc_start) begin
      cnt <= high_n;
    end else if (step) begin
      if (cnt != 16'h0000) begin
        cnt <= cnt - 16'h0001;
      end
    end else if (wr_timer && !running) begin
      cnt <= WDATA;
    end
  end

  // ----------------------------------------------------------------
  // Pulse output and fall event
  // ----------------------------------------------------------------
  logic next_out;
  logic fall_evt;

  always_comb begin
    next_out = PULSE_OUT;
    if (next_state != tapwm_pkg::ST_RUN) begin
      next_out = 1'b0;
    end else if (cyc_start) begin
      next_out = (high_n != 16'h0000);
    end else if (step) begin
      next_out = (cnt > 16'h0001);
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      PULSE_OUT <= 1'b0;
    end else begin
      PULSE_OUT <= next_out;
    end
  end

  // A stop forces the pin low but is not a modulator edge.
  assign fall_evt = running && (next_state == tapwm_pkg::ST_RUN) && PULSE_OUT && !next_out;

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  logic [tapwm_pkg::STAT_W-1:0] stat;
  logic [tapwm_pkg::STAT_W-1:0] mask;
  logic [tapwm_pkg::STAT_W-1:0] evt;

  assign evt[tapwm_pkg::STAT_FALL_BIT] = fall_evt;
  assign evt[tapwm_pkg::STAT_START_BIT] = go;

  genvar gi;
  generate
    for (gi = 0; gi < tapwm_pkg::STAT_W; gi++) begin : g_stat
      // A new event in the clearing cycle keeps the bit set.
      always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
          stat[gi] <= 1'b0;
        end else if (evt[gi]) begin
          stat[gi] <= 1'b1;
        end else if (wr_stat && WDATA[gi]) begin
          stat[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      mask <= '0;
    end else if (wr_mask) begin
      mask <= WDATA[tapwm_pkg::STAT_W-1:0];
    end
  end

  assign IRQ = |(stat & mask);

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [tapwm_pkg::DW-1:0] rd_val;

  always_comb begin
    rd_val = '0;
    case (ADDR)
      tapwm_pkg::REG_MODE: begin
        rd_val[tapwm_pkg::MODE_PWM8_BIT] = pwm8;
        rd_val[tapwm_pkg::MODE_SRC_LSB +: 2] = src;
        rd_val[tapwm_pkg::MODE_TRG_LSB +: 2] = trg;
      end
      tapwm_pkg::REG_START: rd_val[tapwm_pkg::START_BIT] = start_flag;
      tapwm_pkg::REG_TIMER: rd_val = tapwm_pkg::TIMER_READ_VAL;
      tapwm_pkg::REG_STAT: rd_val[tapwm_pkg::STAT_W-1:0] = stat;
      tapwm_pkg::REG_MASK: rd_val[tapwm_pkg::STAT_W-1:0] = mask;
      tapwm_pkg::REG_PORT: rd_val[0] = trig_s2;
      default: rd_val = '0;
    endcase
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      RDATA <= '0;
    end else if (RD) begin
      RDATA <= rd_val;
    end else begin
      RDATA <= '0;
    end
  end

endmodule : tapwm_top

`default_nettype wire
